// File: verilog/pmc_power_mode_controller.sv
// Power mode controller: mode sequencing, clock gating, wake and pin retention
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Normal mode keeps core and the enabled peripherals clocked.
// - Idle bit halts core, peripherals stay clocked; any interrupt ends idle.
// - Suspend and snooze halt core, peripheral clocks, and both fast oscillators.
// - Suspend keeps regulator normal bias; six listed wake sources end it.
// - Snooze puts regulator in low bias, same wake sources as suspend.
// - Timers 3 and 4 may run from slow oscillator in suspend and snooze.
// - Wake from idle, suspend or snooze resumes code, no reset.
// - Stop shuts power nets, holds pins, exits on any reset source.
// - Shutdown powers down, holds pins, exits only on pin or power-on reset.
// - Unused digital peripheral clocks are gated off.
// - Pin configuration retained through most resets when retention is used.
// - Up to 24 port match sources share one vector and wake the device.
module pmc_power_mode_controller #(
  parameter int MATCH_PINS   = 24,
  parameter int PERIPH_COUNT = 8
) (
  input  wire logic                    clk,
  input  wire logic                    reset,
  input  wire logic [3:0]              regAddr,
  input  wire logic [7:0]              regWriteData,
  input  wire logic                    regWrite,
  input  wire logic                    regRead,
  output logic [7:0]                   regReadData,
  input  wire logic                    anyInterrupt,
  input  wire logic                    timer4Event,
  input  wire logic                    serialPeriphPortActivity,
  input  wire logic                    twoWirePortSlaveActivity,
  input  wire logic                    comparator0Falling,
  input  wire logic                    configLogicUnitIrq,
  input  wire logic [MATCH_PINS-1:0]   portPins,
  input  wire logic [MATCH_PINS-1:0]   portMatchValue,
  input  wire logic                    resetPinEvent,
  input  wire logic                    powerOnEvent,
  input  wire logic                    otherResetEvent,
  output logic                         coreClockEnable,
  output logic [PERIPH_COUNT-1:0]      periphClockEnable,
  output logic                         fastOsc24mEnable,
  output logic                         fastOsc72mEnable,
  output logic                         slowOsc80kTimerEnable,
  output logic                         regulatorLowBias,
  output logic                         powerNetsEnable,
  output logic                         pinHold,
  output logic                         portMatchIrq,
  output logic                         wakeResume,
  output logic                         deviceResetRequest,
  output pmc_pkg::pmc_mode_t           currentMode
);
  import pmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Local field layout

  // Widths the register map can serve; the parameters may only shrink them
  localparam int MATCH_LANES    = 24;
  localparam int PERIPH_LANES   = 8;
  localparam int BYTE_WIDTH     = 8;
  localparam int MATCH_LO_BASE  = 0;
  localparam int MATCH_MID_BASE = 8;
  localparam int MATCH_HI_BASE  = 16;
  localparam int CLK_SEL_WIDTH  = 2;
  localparam int RETAIN_BIT     = 0;

  // Larger values would leave lanes or clocks with no register behind them
  if (MATCH_PINS < 1 || MATCH_PINS > MATCH_LANES)
  begin : gBadMatchPins
    $error("MATCH_PINS must lie between 1 and 24");
  end
  if (PERIPH_COUNT < 1 || PERIPH_COUNT > PERIPH_LANES)
  begin : gBadPeriphCount
    $error("PERIPH_COUNT must lie between 1 and 8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    pmc_mode_t         mode;
    logic              idleReq;
    logic              stopReq;
    logic              suspendReq;
    logic              snoozeReq;
    logic              stopConfigFlag;
    logic [1:0]        clockSelect;
    logic [7:0]        periphEnable;
    logic [23:0]       matchEnable;
    logic [7:0]        wakeEnable;
    logic              retainEnable;
    logic              retainLatched;
    logic              wakePulse;
    logic              resetReq;
    logic [7:0]        readData;
  } pmc_state_t;

  // Power-up image; the reset branch loads only this constant
  localparam pmc_state_t STATE_RESET = '{
    mode:           MODE_NORMAL,
    idleReq:        1'b0,
    stopReq:        1'b0,
    suspendReq:     1'b0,
    snoozeReq:      1'b0,
    stopConfigFlag: 1'b0,
    clockSelect:    CLK_SEL_RESET,
    periphEnable:   PERIPH_ENABLE_RESET,
    matchEnable:    24'h000000,
    wakeEnable:     WAKE_ENABLE_RESET,
    retainEnable:   1'b0,
    retainLatched:  1'b0,
    wakePulse:      1'b0,
    resetReq:       1'b0,
    readData:       8'h00
  };

  pmc_state_t state_q;
  pmc_state_t state_d;

  ////////////////////////////////////////////////////////////////////////////
  // Port match and wake decode

  logic [MATCH_LANES-1:0] matchHits;
  logic [WAKE_COUNT-1:0] wakeSources;
  logic        lowPowerWake;

  // Unused match lanes stay zero so the shared vector ignores them
  genvar gi;
  generate
    for (gi = 0; gi < MATCH_LANES; gi++)
    begin : gMatch
      if (gi < MATCH_PINS)
      begin : gUsed
        assign matchHits[gi] = state_q.matchEnable[gi] & (portPins[gi] != portMatchValue[gi]);
      end
      else
      begin : gUnused
        assign matchHits[gi] = 1'b0;
      end
    end
  endgenerate

  // Wake inputs are levels; a pulse must span one rising edge
  always_comb
  begin
    wakeSources               = '0;
    wakeSources[WAKE_TIMER4]  = timer4Event;
    wakeSources[WAKE_SERIAL]  = serialPeriphPortActivity;
    wakeSources[WAKE_TWOWIRE] = twoWirePortSlaveActivity;
    wakeSources[WAKE_MATCH]   = |matchHits;
    wakeSources[WAKE_COMP0]   = comparator0Falling;
    wakeSources[WAKE_CLU]     = configLogicUnitIrq;
  end

  // A masked port match still raises portMatchIrq; masked sources cannot end a sleep
  assign lowPowerWake = |(wakeSources & state_q.wakeEnable[WAKE_COUNT-1:0]);

  function automatic logic isLowPower(input pmc_mode_t m);
    isLowPower = (m == MODE_SUSPEND) || (m == MODE_SNOOZE);
  endfunction : isLowPower

  function automatic logic isPoweredDown(input pmc_mode_t m);
    isPoweredDown = (m == MODE_STOP) || (m == MODE_SHUTDOWN);
  endfunction : isPoweredDown

  // Normal and idle keep the 24 MHz oscillator, the 72 MHz one when selected, and enabled peripheral clocks alive
  function automatic logic keepsFastClocks(input pmc_mode_t m);
    keepsFastClocks = (m == MODE_NORMAL) || (m == MODE_IDLE);
  endfunction : keepsFastClocks

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    state_d           = state_q;
    state_d.wakePulse = 1'b0;
    state_d.resetReq  = 1'b0;
    state_d.readData  = 8'h00;

    // Register writes; powered-down modes ignore bus writes but still serve reads
    if (regWrite && !isPoweredDown(state_q.mode))
    begin
      unique case (regAddr)
        ADDR_POWER_CONTROL_ZERO:
        begin
          state_d.idleReq = regWriteData[IDLE_BIT];
          state_d.stopReq = regWriteData[STOP_BIT];
        end
        ADDR_POWER_CONTROL_ONE:
        begin
          state_d.suspendReq = regWriteData[SUSPEND_BIT];
          state_d.snoozeReq  = regWriteData[SNOOZE_BIT];
        end
        ADDR_REGULATOR_CONTROL: state_d.stopConfigFlag = regWriteData[STOP_CONFIG_FLAG_BIT];
        ADDR_CLOCK_SELECT:      state_d.clockSelect    = regWriteData[CLK_SEL_WIDTH-1:0];
        ADDR_PERIPH_ENABLE:     state_d.periphEnable   = regWriteData;
        ADDR_MATCH_ENABLE_LO:   state_d.matchEnable[MATCH_LO_BASE +: BYTE_WIDTH]  = regWriteData;
        ADDR_MATCH_ENABLE_MID:  state_d.matchEnable[MATCH_MID_BASE +: BYTE_WIDTH] = regWriteData;
        ADDR_MATCH_ENABLE_HI:   state_d.matchEnable[MATCH_HI_BASE +: BYTE_WIDTH]  = regWriteData;
        ADDR_RETAIN_CONTROL:    state_d.retainEnable   = regWriteData[RETAIN_BIT];
        ADDR_WAKE_ENABLE:       state_d.wakeEnable     = regWriteData;
        default:                state_d.readData       = 8'h00;
      endcase
    end

    // Read data stands one cycle only; the bus never waits
    if (regRead)
    begin
      unique case (regAddr)
        ADDR_POWER_CONTROL_ZERO: state_d.readData = {6'h00, state_q.stopReq, state_q.idleReq};
        ADDR_POWER_CONTROL_ONE:  state_d.readData = {6'h00, state_q.snoozeReq, state_q.suspendReq};
        ADDR_REGULATOR_CONTROL:  state_d.readData = {7'h00, state_q.stopConfigFlag};
        ADDR_CLOCK_SELECT:       state_d.readData = {6'h00, state_q.clockSelect};
        ADDR_PERIPH_ENABLE:      state_d.readData = state_q.periphEnable;
        ADDR_MATCH_ENABLE_LO:    state_d.readData = state_q.matchEnable[MATCH_LO_BASE +: BYTE_WIDTH];
        ADDR_MATCH_ENABLE_MID:   state_d.readData = state_q.matchEnable[MATCH_MID_BASE +: BYTE_WIDTH];
        ADDR_MATCH_ENABLE_HI:    state_d.readData = state_q.matchEnable[MATCH_HI_BASE +: BYTE_WIDTH];
        ADDR_STATUS:             state_d.readData = {state_q.retainLatched, 4'h0, 3'(state_q.mode)};
        ADDR_RETAIN_CONTROL:     state_d.readData = {7'h00, state_q.retainEnable};
        ADDR_WAKE_ENABLE:        state_d.readData = state_q.wakeEnable;
        default:                 state_d.readData = 8'h00;
      endcase
    end

    unique case (state_q.mode)
      MODE_NORMAL:
      begin
        // Requests act one cycle after the write; stop outranks the rest
        if (state_q.stopReq)
        begin
          state_d.mode          = state_q.stopConfigFlag ? MODE_SHUTDOWN : MODE_STOP;
          // Captured at entry so a later write cannot release held pins
          state_d.retainLatched = state_q.retainEnable;
        end
        else if (state_q.snoozeReq)
          state_d.mode = MODE_SNOOZE;
        else if (state_q.suspendReq)
          state_d.mode = MODE_SUSPEND;
        else if (state_q.idleReq)
          state_d.mode = MODE_IDLE;
      end
      MODE_IDLE:
      begin
        // Only the interrupt line ends idle, not the sleep wake sources
        if (anyInterrupt)
        begin
          state_d.mode      = MODE_NORMAL;
          state_d.idleReq   = 1'b0;
          state_d.wakePulse = 1'b1;
        end
      end
      MODE_SUSPEND, MODE_SNOOZE:
      begin
        if (lowPowerWake)
        begin
          state_d.mode       = MODE_NORMAL;
          state_d.suspendReq = 1'b0;
          state_d.snoozeReq  = 1'b0;
          // A stale idle bit would otherwise drop straight back into idle
          state_d.idleReq    = 1'b0;
          state_d.wakePulse  = 1'b1;
        end
      end
      MODE_STOP:
      begin
        // Any reset source restarts the core from its reset vector
        if (resetPinEvent || powerOnEvent || otherResetEvent)
        begin
          state_d.mode     = MODE_NORMAL;
          state_d.stopReq  = 1'b0;
          state_d.resetReq = 1'b1;
        end
      end
      MODE_SHUTDOWN:
      begin
        // Only pin or power-on reset ends shutdown
        if (resetPinEvent || powerOnEvent)
        begin
          state_d.mode     = MODE_NORMAL;
          state_d.stopReq  = 1'b0;
          state_d.resetReq = 1'b1;
        end
      end
      default:
      begin
        // Undefined mode code: fall back to normal so the core is never stranded
        state_d.mode = MODE_NORMAL;
      end
    endcase

    // Power-on always drops retention; other resets keep it when enabled
    if (powerOnEvent)
      state_d.retainLatched = 1'b0;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= STATE_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Core clock runs only in normal mode
  assign coreClockEnable = (state_q.mode == MODE_NORMAL);

  // Peripheral clocks gated by enable; halted in suspend, snooze and power-down
  assign periphClockEnable = keepsFastClocks(state_q.mode)
                             ? state_q.periphEnable[PERIPH_COUNT-1:0] : '0;

  assign fastOsc24mEnable = keepsFastClocks(state_q.mode);
  // No hardware check of the clock select before sleep; firmware owns that order
  assign fastOsc72mEnable = keepsFastClocks(state_q.mode)
                            && (state_q.clockSelect == CLK_SEL_FAST_OSC_72M);

  // Slow oscillator only while the sleep timers need it
  assign slowOsc80kTimerEnable = isLowPower(state_q.mode);
  // Low bias trades wake latency for sleep current
  assign regulatorLowBias      = (state_q.mode == MODE_SNOOZE);
  assign powerNetsEnable       = !isPoweredDown(state_q.mode);
  // Retained pins stay held after exit until a power-on reset
  assign pinHold               = isPoweredDown(state_q.mode) || state_q.retainLatched;
  assign portMatchIrq          = |matchHits;
  assign wakeResume            = state_q.wakePulse;
  // One-cycle pulse; the system reset logic stretches it
  assign deviceResetRequest    = state_q.resetReq;
  assign currentMode           = state_q.mode;
  assign regReadData           = state_q.readData;
endmodule : pmc_power_mode_controller
`default_nettype wire

// File: verilog/pmc_pkg.sv
// Package for the power mode controller: register map, fields, modes
`default_nettype none
package pmc_pkg;
  localparam logic [3:0] ADDR_POWER_CONTROL_ZERO = 4'h0;
  localparam logic [3:0] ADDR_POWER_CONTROL_ONE  = 4'h1;
  localparam logic [3:0] ADDR_REGULATOR_CONTROL  = 4'h2;
  localparam logic [3:0] ADDR_CLOCK_SELECT       = 4'h3;
  localparam logic [3:0] ADDR_PERIPH_ENABLE      = 4'h4;
  localparam logic [3:0] ADDR_MATCH_ENABLE_LO    = 4'h5;
  localparam logic [3:0] ADDR_MATCH_ENABLE_MID   = 4'h6;
  localparam logic [3:0] ADDR_MATCH_ENABLE_HI    = 4'h7;
  localparam logic [3:0] ADDR_STATUS             = 4'h8;
  localparam logic [3:0] ADDR_RETAIN_CONTROL     = 4'h9;
  localparam logic [3:0] ADDR_WAKE_ENABLE        = 4'hA;

  // power_control_zero fields
  localparam int IDLE_BIT    = 0;
  localparam int STOP_BIT    = 1;
  // power_control_one fields
  localparam int SUSPEND_BIT = 0;
  localparam int SNOOZE_BIT  = 1;
  // regulator_control field
  localparam int STOP_CONFIG_FLAG_BIT = 0;
  // clock select encoding
  localparam logic [1:0] CLK_SEL_FAST_OSC_24M = 2'h0;
  localparam logic [1:0] CLK_SEL_FAST_OSC_72M = 2'h1;
  localparam logic [1:0] CLK_SEL_EXTERNAL     = 2'h2;
  localparam logic [1:0] CLK_SEL_RESET        = 2'h0;
  // wake source indices
  localparam int WAKE_TIMER4  = 0;
  localparam int WAKE_SERIAL  = 1;
  localparam int WAKE_TWOWIRE = 2;
  localparam int WAKE_MATCH   = 3;
  localparam int WAKE_COMP0   = 4;
  localparam int WAKE_CLU     = 5;
  localparam int WAKE_COUNT   = 6;
  localparam logic [7:0] WAKE_ENABLE_RESET  = 8'h3F;
  localparam logic [7:0] PERIPH_ENABLE_RESET = 8'h00;

  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_IDLE,
    MODE_SUSPEND,
    MODE_SNOOZE,
    MODE_STOP,
    MODE_SHUTDOWN
  } pmc_mode_t;
endpackage : pmc_pkg
`default_nettype wire

// File: testbench/pmc_power_mode_controller_properties.sv
// Port-level assertions for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller_properties
  import pmc_pkg::*;
#(
  parameter int PERIPH_COUNT = 8
) (
  input wire logic                    clk,
  input wire logic                    reset,
  input wire logic [3:0]              regAddr,
  input wire logic [7:0]              regWriteData,
  input wire logic                    regWrite,
  input wire logic                    anyInterrupt,
  input wire logic                    resetPinEvent,
  input wire logic                    powerOnEvent,
  input wire logic                    otherResetEvent,
  input wire logic                    coreClockEnable,
  input wire logic [PERIPH_COUNT-1:0] periphClockEnable,
  input wire logic                    fastOsc24mEnable,
  input wire logic                    fastOsc72mEnable,
  input wire logic                    slowOsc80kTimerEnable,
  input wire logic                    regulatorLowBias,
  input wire logic                    powerNetsEnable,
  input wire logic                    pinHold,
  input wire logic                    wakeResume,
  input wire logic                    deviceResetRequest,
  input wire pmc_pkg::pmc_mode_t      currentMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////
  property p_normal; currentMode == MODE_NORMAL |-> coreClockEnable && fastOsc24mEnable && powerNetsEnable; endproperty
  a_normal: assert property (p_normal) else $error("normal mode clocks off");
  property p_idle; currentMode == MODE_IDLE |-> !coreClockEnable && fastOsc24mEnable; endproperty
  a_idle: assert property (p_idle) else $error("idle clocks wrong");
  property p_idle_wake; currentMode == MODE_IDLE && anyInterrupt |=> currentMode == MODE_NORMAL && wakeResume;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake missed");
  property p_sleep; currentMode inside {MODE_SUSPEND, MODE_SNOOZE} |-> !coreClockEnable && periphClockEnable == '0
    && !fastOsc24mEnable && !fastOsc72mEnable && slowOsc80kTimerEnable; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep clocks wrong");
  property p_bias; 1'b1 |-> regulatorLowBias == (currentMode == MODE_SNOOZE); endproperty
  a_bias: assert property (p_bias) else $error("regulator bias wrong");
  property p_off; currentMode inside {MODE_STOP, MODE_SHUTDOWN} |-> !powerNetsEnable && pinHold; endproperty
  a_off: assert property (p_off) else $error("power nets or pins wrong");
  property p_stop_exit; currentMode == MODE_STOP && (resetPinEvent || powerOnEvent || otherResetEvent)
    |=> currentMode == MODE_NORMAL && deviceResetRequest; endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("stop exit wrong");
  property p_shut_exit; currentMode == MODE_SHUTDOWN && (resetPinEvent || powerOnEvent)
    |=> currentMode == MODE_NORMAL && deviceResetRequest; endproperty
  a_shut_exit: assert property (p_shut_exit) else $error("shutdown exit wrong");
  property p_shut_hold; currentMode == MODE_SHUTDOWN && !resetPinEvent && !powerOnEvent
    |=> currentMode == MODE_SHUTDOWN; endproperty
  a_shut_hold: assert property (p_shut_hold) else $error("shutdown left early");
  property p_idle_entry; regWrite && regAddr == ADDR_POWER_CONTROL_ZERO && regWriteData == 8'h01
    && currentMode == MODE_NORMAL |=> ##1 currentMode == MODE_IDLE; endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
endmodule : pmc_power_mode_controller_properties

bind pmc_power_mode_controller pmc_power_mode_controller_properties #(.PERIPH_COUNT(PERIPH_COUNT)) u_props (
  .clk(clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite),
  .anyInterrupt(anyInterrupt), .resetPinEvent(resetPinEvent), .powerOnEvent(powerOnEvent),
  .otherResetEvent(otherResetEvent), .coreClockEnable(coreClockEnable), .periphClockEnable(periphClockEnable),
  .fastOsc24mEnable(fastOsc24mEnable), .fastOsc72mEnable(fastOsc72mEnable),
  .slowOsc80kTimerEnable(slowOsc80kTimerEnable), .regulatorLowBias(regulatorLowBias),
  .powerNetsEnable(powerNetsEnable), .pinHold(pinHold), .wakeResume(wakeResume),
  .deviceResetRequest(deviceResetRequest), .currentMode(currentMode));
`default_nettype wire

// File: testbench/pmc_power_mode_controller_test.sv
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module pmc_power_mode_controller_test;
  import pmc_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWriteData = 8'h00;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic [9:0] ev = 10'h000;
  logic [7:0] regReadData, periphClockEnable;
  logic       coreClockEnable, fastOsc24mEnable, fastOsc72mEnable, slowOsc80kTimerEnable;
  logic       regulatorLowBias, powerNetsEnable, pinHold, portMatchIrq, wakeResume, deviceResetRequest;
  pmc_mode_t  currentMode;
  int         miscompares = 0;
  int         checks = 0;
  int         cycles = 0;
  pmc_power_mode_controller dut_u (
    .clk(clk), .reset(reset), .regAddr(regAddr), .regWriteData(regWriteData),
    .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
    .anyInterrupt(ev[0]), .timer4Event(ev[1]), .serialPeriphPortActivity(ev[2]),
    .twoWirePortSlaveActivity(ev[3]), .comparator0Falling(ev[5]), .configLogicUnitIrq(ev[6]),
    .portPins({ev[4], 23'h000000}), .portMatchValue(24'h000000), .resetPinEvent(ev[7]),
    .powerOnEvent(ev[8]), .otherResetEvent(ev[9]), .coreClockEnable(coreClockEnable),
    .periphClockEnable(periphClockEnable), .fastOsc24mEnable(fastOsc24mEnable),
    .fastOsc72mEnable(fastOsc72mEnable), .slowOsc80kTimerEnable(slowOsc80kTimerEnable),
    .regulatorLowBias(regulatorLowBias), .powerNetsEnable(powerNetsEnable), .pinHold(pinHold),
    .portMatchIrq(portMatchIrq), .wakeResume(wakeResume), .deviceResetRequest(deviceResetRequest),
    .currentMode(currentMode));
  always #4 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (miscompares == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask : wr
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk);
    regRead <= 1'b0;
    @(negedge clk);
    chk(n, e, regReadData);
  endtask : rd
  // Mode follows the request one edge after the write lands
  task automatic settle;
    @(posedge clk);
    @(negedge clk);
  endtask : settle
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    @(negedge clk);
  endtask : pulse
  task automatic chk_mode(input pmc_mode_t m);
    chk("mode", 8'(m), 8'(currentMode));
  endtask : chk_mode
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk_mode(MODE_NORMAL);
    chk("core", 8'h01, 8'(coreClockEnable));
    chk("powerNets", 8'h01, 8'(powerNetsEnable));
    rd(4'hA, 8'h3F, "wakeEnable");
    rd(4'h4, 8'h00, "periphEnable");
    wr(4'hB, 8'hFF);
    rd(4'hB, 8'h00, "unmapped");
    wr(4'h8, 8'hFF);
    rd(4'h8, 8'h00, "status");
    wr(4'h3, 8'h01);
    @(negedge clk);
    chk("fast72", 8'h01, 8'(fastOsc72mEnable));
    wr(4'h3, 8'h00);
  endtask : t_reset
  task automatic t_idle;
    wr(4'h4, 8'hA5);
    wr(4'h0, 8'h01);
    settle();
    chk_mode(MODE_IDLE);
    chk("periphIdle", 8'hA5, periphClockEnable);
    chk("coreIdle", 8'h00, 8'(coreClockEnable));
    pulse(0);
    chk_mode(MODE_NORMAL);
    chk("resume", 8'h01, 8'(wakeResume));
    rd(4'h0, 8'h00, "pcZero");
  endtask : t_idle
  // Every wake source in both sleep modes, then a masked source
  task automatic t_sleep;
    wr(4'h7, 8'h80);
    for (int m = 1; m <= 2; m++)
      for (int i = 0; i < 6; i++)
      begin
        wr(4'h1, 8'(m));
        settle();
        chk_mode(m == 1 ? MODE_SUSPEND : MODE_SNOOZE);
        chk("periphSleep", 8'h00, periphClockEnable);
        chk("coreSleep", 8'h00, 8'(coreClockEnable));
        chk("fast24Sleep", 8'h00, 8'(fastOsc24mEnable));
        chk("slowOsc", 8'h01, 8'(slowOsc80kTimerEnable));
        chk("lowBias", 8'(m - 1), 8'(regulatorLowBias));
        pulse(i + 1);
        chk_mode(MODE_NORMAL);
        chk("resume", 8'h01, 8'(wakeResume));
      end
    rd(4'h1, 8'h00, "pcOne");
    wr(4'hA, 8'h3E);
    wr(4'h1, 8'h01);
    settle();
    pulse(1);
    chk_mode(MODE_SUSPEND);
    wr(4'hA, 8'h3F);
    pulse(1);
    chk_mode(MODE_NORMAL);
    @(posedge clk);
    ev[4] <= 1'b1;
    @(negedge clk);
    chk("matchIrq", 8'h01, 8'(portMatchIrq));
    @(posedge clk);
    ev[4] <= 1'b0;
  endtask : t_sleep
  // Stop ends on each reset source; writes made while stopped are dropped
  task automatic t_stop;
    wr(4'h2, 8'h00);
    for (int i = 7; i <= 9; i++)
    begin
      wr(4'h0, 8'h02);
      settle();
      chk_mode(MODE_STOP);
      chk("pinHold", 8'h01, 8'(pinHold));
      chk("powerNets", 8'h00, 8'(powerNetsEnable));
      wr(4'h3, 8'h01);
      pulse(i);
      chk_mode(MODE_NORMAL);
      chk("resetReq", 8'h01, 8'(deviceResetRequest));
      rd(4'h3, 8'h00, "clockSelect");
      rd(4'h0, 8'h00, "pcZero");
    end
  endtask : t_stop
  task automatic t_shut;
    wr(4'h9, 8'h01);
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h02);
    settle();
    chk_mode(MODE_SHUTDOWN);
    pulse(9);
    chk_mode(MODE_SHUTDOWN);
    pulse(7);
    chk_mode(MODE_NORMAL);
    chk("resetReq", 8'h01, 8'(deviceResetRequest));
    chk("retained", 8'h01, 8'(pinHold));
    rd(4'h8, 8'h80, "status");
    pulse(8);
    chk("released", 8'h00, 8'(pinHold));
    wr(4'h0, 8'h02);
    settle();
    chk_mode(MODE_SHUTDOWN);
    pulse(8);
    chk_mode(MODE_NORMAL);
    chk("resetReq", 8'h01, 8'(deviceResetRequest));
    chk("porRelease", 8'h00, 8'(pinHold));
  endtask : t_shut
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    t_reset();
    t_idle();
    t_sleep();
    t_stop();
    t_shut();
    report_and_stop();
  end
endmodule : pmc_power_mode_controller_test
`default_nettype wire
